// >>> hw/ufc_channel.sv
// one uart channel: registers, special detect, flow control, summary
// assumes host strobes and serial-side handshakes synchronous to clock
`default_nettype none
module ufc_channel
	import ufc_pkg::*;
#(
	parameter int FIFO_DEPTH = ufc_pkg::RX_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic chipSelN,
	input wire logic readN,
	input wire logic writeN,
	input wire logic [2:0] addr,
	input wire logic [7:0] busDataIn,
	output logic [7:0] busDataOut,
	output logic busDataOe,
	input wire logic fifoSummarySelectN,
	input wire logic [3:0] allTxSpaceN,
	input wire logic [3:0] allRxAvailN,
	input wire logic irqDriveSelect,
	output logic irqOut,
	output logic irqOe,
	input wire logic [7:0] rxChar,
	input wire logic rxValid,
	output logic rxReady,
	output logic [7:0] txChar,
	output logic txValid,
	input wire logic txReady,
	input wire logic ctsN,
	input wire logic dsrN,
	input wire logic riN,
	input wire logic cdN,
	output logic rtsN,
	output logic dtrN,
	output logic serialTxOut,
	output logic infraredTxOut,
	output logic txSpaceFlagN,
	output logic rxAvailFlagN
);
	import ufc_pkg::*;
	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	// =====================================================
	// state
	logic [7:0] ier_q, ier_d, fcr_q, fcr_d, lcr_q, lcr_d, mcr_q, mcr_d;
	logic [7:0] spr_q, spr_d, efr_q, efr_d, dld_q, dld_d;
	logic [7:0] onOne_q, onOne_d, onTwo_q, onTwo_d;
	logic [7:0] offOne_q, offOne_d, offTwo_q, offTwo_d;
	logic [7:0] thr_q, thr_d, busData_q, busData_d, fifo_ready_summary_q, fifo_ready_summary_d;
	logic [7:0] divLow_q = DIV_LOW_POWERUP;
	logic [7:0] divHigh_q = DIV_HIGH_POWERUP;
	logic [7:0] divLow_d, divHigh_d;
	logic thrFull_q, thrFull_d, rdPrev_q, rdPrev_d, wrPrev_q, wrPrev_d;
	logic specFlag_q, specFlag_d, offFlag_q, offFlag_d;
	logic swHalt_q, swHalt_d, rtsHalt_q, rtsHalt_d;
	logic [3:0] delta_q, delta_d, modemPrev_q;
	logic [3:0] modemNow;

	// =====================================================
	// bus decode
	logic rdAct, wrAct, rdStart, wrStart, enhBank, divBank, enhEn;
	logic [7:0] rdMux, interrupt_source_reg, line_status_reg, modem_status_reg;
	assign rdAct = !chipSelN && !readN;
	assign wrAct = !chipSelN && !writeN;
	assign rdStart = rdAct && !rdPrev_q;
	assign wrStart = wrAct && !wrPrev_q;
	assign enhBank = lcr_q == LCR_ENH_KEY;
	assign divBank = lcr_q[LCR_DIV_BIT] && !enhBank;
	assign enhEn = efr_q[EFR_ENH_BIT];

	// =====================================================
	// receive path
	logic [7:0] fifoHead;
	logic fifoInReady, fifoOutValid, fifoPop, fifoPush;
	logic [CW-1:0] fifoCount;
	logic [1:0] rxMode;
	logic mOffOne, mOffTwo, mOnOne, mOnTwo, isOff, isOn, isSpec, dropChar, rxTake;
	assign rxMode = efr_q[1:0];
	assign mOffOne = rxChar[7:0] == offOne_q[7:0];
	assign mOffTwo = rxChar[7:0] == offTwo_q[7:0];
	assign mOnOne = rxChar == onOne_q;
	assign mOnTwo = rxChar == onTwo_q;
	assign isOff = (rxMode == RXFC_FIRST && mOffOne) || (rxMode == RXFC_SECOND && mOffTwo)
		|| (rxMode == RXFC_BOTH && (mOffOne || mOffTwo));
	assign isOn = (rxMode == RXFC_FIRST && mOnOne) || (rxMode == RXFC_SECOND && mOnTwo)
		|| (rxMode == RXFC_BOTH && (mOnOne || mOnTwo));
	assign isSpec = efr_q[EFR_SPEC_BIT] && mOffTwo;
	// flow characters never enter the fifo; special alone is stored
	assign dropChar = isOff || isOn;
	assign rxReady = dropChar || fifoInReady;
	assign rxTake = rxValid && rxReady;
	assign fifoPush = rxValid && !dropChar;
	assign fifoPop = rdStart && addr == ADDR_DATA && !divBank;

	ufc_rx_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) rxFifo (
		.clock(clock),
		.rst(rst),
		.inData(rxChar),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.outData(fifoHead),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.count(fifoCount)
	);

	// =====================================================
	// trigger level and auto rts
	logic [3:0] trig;
	logic rxTrig, autoRts;
	always_comb begin
		case (fcr_q[7:6])
			2'b00: trig = TRIG_L0;
			2'b01: trig = TRIG_L1;
			2'b10: trig = TRIG_L2;
			2'b11: trig = TRIG_L3;
			default: trig = TRIG_L0;
		endcase
	end
	assign autoRts = efr_q[EFR_RTS_BIT];
	assign rxTrig = CW'(trig) <= fifoCount;

	always_comb begin
		rtsHalt_d = rtsHalt_q;
		if (!autoRts) begin
			rtsHalt_d = 1'b0;
		end else if (fifoCount >= CW'(trig + TRIG_HYST)) begin
			rtsHalt_d = 1'b1;
		end else if (fifoCount < CW'(trig)) begin
			rtsHalt_d = 1'b0;
		end
	end
	// without auto rts the pin follows the control bit only
	assign rtsN = !mcr_q[MCR_RTS_BIT] || (autoRts && rtsHalt_q);
	assign dtrN = !mcr_q[MCR_DTR_BIT];

	// =====================================================
	// transmit gating
	logic ctsHalt;
	assign ctsHalt = efr_q[EFR_CTS_BIT] && ctsN;
	assign txValid = thrFull_q && !ctsHalt && !swHalt_q;
	assign txChar = thr_q;
	assign serialTxOut = 1'b1;
	assign infraredTxOut = 1'b0;
	assign txSpaceFlagN = thrFull_q;
	assign rxAvailFlagN = !fifoOutValid;

	// =====================================================
	// status views
	assign modemNow = {cdN, riN, dsrN, ctsN};
	assign modem_status_reg = {~modemNow, delta_q};
	assign line_status_reg = {1'b0, !thrFull_q, !thrFull_q, 4'h0, fifoOutValid};
	always_comb begin
		if (ier_q[IER_RX_BIT] && rxTrig) begin
			interrupt_source_reg = ISR_RXDATA;
		end else if (ier_q[IER_SPEC_BIT] && (specFlag_q || offFlag_q)) begin
			interrupt_source_reg = ISR_SPECIAL;
		end else if (ier_q[IER_MODEM_BIT] && delta_q != 4'h0) begin
			interrupt_source_reg = ISR_MODEM;
		end else begin
			interrupt_source_reg = ISR_NONE;
		end
	end
	// three-state unless selected or enabled; low while in reset
	assign irqOut = !rst && !interrupt_source_reg[0];
	assign irqOe = rst ? irqDriveSelect : (irqDriveSelect || mcr_q[MCR_IRQ_EN_BIT]);

	always_comb begin
		case (addr)
			ADDR_DATA: rdMux = divBank ? divLow_q : fifoHead;
			ADDR_IER: rdMux = divBank ? divHigh_q : ier_q;
			ADDR_ISR: rdMux = enhBank ? efr_q : (divBank ? dld_q : interrupt_source_reg);
			ADDR_LCR: rdMux = lcr_q;
			ADDR_MCR: rdMux = enhBank ? onOne_q : mcr_q;
			ADDR_LSR: rdMux = enhBank ? onTwo_q : line_status_reg;
			ADDR_MSR: rdMux = enhBank ? offOne_q : modem_status_reg;
			ADDR_SPR: rdMux = enhBank ? offTwo_q : spr_q;
			default: rdMux = RST_ONES;
		endcase
	end
	assign fifo_ready_summary_d = {allRxAvailN, ~allTxSpaceN};
	assign busDataOe = rdAct || !fifoSummarySelectN;
	assign busDataOut = busData_q;

	// =====================================================
	// register next values
	always_comb begin
		ier_d = ier_q;
		fcr_d = fcr_q;
		lcr_d = lcr_q;
		mcr_d = mcr_q;
		spr_d = spr_q;
		efr_d = efr_q;
		dld_d = dld_q;
		onOne_d = onOne_q;
		onTwo_d = onTwo_q;
		offOne_d = offOne_q;
		offTwo_d = offTwo_q;
		thr_d = thr_q;
		thrFull_d = thrFull_q;
		divLow_d = divLow_q;
		divHigh_d = divHigh_q;
		specFlag_d = specFlag_q;
		offFlag_d = offFlag_q;
		swHalt_d = swHalt_q;
		delta_d = delta_q;
		rdPrev_d = rdAct;
		wrPrev_d = wrAct;
		busData_d = busData_q;
		if (txValid && txReady) begin
			thrFull_d = 1'b0;
		end
		if (wrStart) begin
			case (addr)
				ADDR_DATA: begin
					if (divBank) begin
						divLow_d = busDataIn;
					end else begin
						thr_d = busDataIn;
						thrFull_d = 1'b1;
					end
				end
				ADDR_IER: begin
					if (divBank) begin
						divHigh_d = busDataIn;
					end else begin
						ier_d = {enhEn ? busDataIn[7:4] : ier_q[7:4], busDataIn[3:0]};
					end
				end
				ADDR_ISR: begin
					if (enhBank) begin
						efr_d = busDataIn;
					end else if (divBank) begin
						dld_d = enhEn ? busDataIn : dld_q;
					end else begin
						fcr_d = {busDataIn[7:6], enhEn ? busDataIn[5:4] : fcr_q[5:4],
							busDataIn[3:0]};
					end
				end
				ADDR_LCR: lcr_d = busDataIn;
				ADDR_MCR: begin
					if (enhBank) begin
						onOne_d = busDataIn;
					end else begin
						mcr_d = {enhEn ? busDataIn[7:5] : mcr_q[7:5], busDataIn[4:0]};
					end
				end
				ADDR_LSR: onTwo_d = enhBank ? busDataIn : onTwo_q;
				ADDR_MSR: offOne_d = enhBank ? busDataIn : offOne_q;
				ADDR_SPR: begin
					if (enhBank) begin
						offTwo_d = busDataIn;
					end else begin
						spr_d = busDataIn;
					end
				end
				default: spr_d = spr_q;
			endcase
		end
		// clears first, so that a same-cycle event still sets
		if (rdStart && addr == ADDR_ISR && !enhBank && !divBank) begin
			specFlag_d = 1'b0;
			offFlag_d = 1'b0;
		end
		if (rdStart && addr == ADDR_MSR && !enhBank) begin
			delta_d = 4'h0;
		end
		delta_d = delta_d | {modemNow[3] ^ modemPrev_q[3], modemNow[2] && !modemPrev_q[2],
			modemNow[1:0] ^ modemPrev_q[1:0]};
		if (rxMode == RXFC_OFF) begin
			swHalt_d = 1'b0;
		end
		if (rxTake) begin
			if (isOff) begin
				swHalt_d = 1'b1;
				offFlag_d = 1'b1;
			end
			if (isOn) begin
				swHalt_d = 1'b0;
			end
			if (isSpec) begin
				specFlag_d = 1'b1;
			end
		end
		if (!fifoSummarySelectN) begin
			busData_d = fifo_ready_summary_q;
		end else if (rdStart) begin
			busData_d = rdMux;
		end
	end

	// =====================================================
	// registers
	always_ff @(posedge clock) begin
		divLow_q <= divLow_d;
		divHigh_q <= divHigh_d;
		modemPrev_q <= modemNow;
		if (rst) begin
			ier_q <= RST_ZERO;
			fcr_q <= RST_ZERO;
			lcr_q <= RST_ZERO;
			mcr_q <= RST_ZERO;
			efr_q <= RST_ZERO;
			dld_q <= RST_ZERO;
			onOne_q <= RST_ZERO;
			onTwo_q <= RST_ZERO;
			offOne_q <= RST_ZERO;
			offTwo_q <= RST_ZERO;
			spr_q <= RST_ONES;
			fifo_ready_summary_q <= RST_ONES;
			busData_q <= RST_ONES;
			thr_q <= RST_ZERO;
			thrFull_q <= 1'b0;
			rdPrev_q <= 1'b0;
			wrPrev_q <= 1'b0;
			specFlag_q <= 1'b0;
			offFlag_q <= 1'b0;
			swHalt_q <= 1'b0;
			rtsHalt_q <= 1'b0;
			delta_q <= 4'h0;
		end else begin
			ier_q <= ier_d;
			fcr_q <= fcr_d;
			lcr_q <= lcr_d;
			mcr_q <= mcr_d;
			efr_q <= efr_d;
			dld_q <= dld_d;
			onOne_q <= onOne_d;
			onTwo_q <= onTwo_d;
			offOne_q <= offOne_d;
			offTwo_q <= offTwo_d;
			spr_q <= spr_d;
			fifo_ready_summary_q <= fifo_ready_summary_d;
			busData_q <= busData_d;
			thr_q <= thr_d;
			thrFull_q <= thrFull_d;
			rdPrev_q <= rdPrev_d;
			wrPrev_q <= wrPrev_d;
			specFlag_q <= specFlag_d;
			offFlag_q <= offFlag_d;
			swHalt_q <= swHalt_d;
			rtsHalt_q <= rtsHalt_d;
			delta_q <= delta_d;
		end
	end
endmodule : ufc_channel
`default_nettype wire

// >>> hw/ufc_pkg.sv
// constants of one uart channel: register map, reset values, field positions
// assumes a host bus with three address lines and 8-bit data
//
// Notes on behaviour
// - special detect: match second off char, flag
// - compare bit 0 with received lsb
// - mode 10 plus detect: both act independently
// - mode 01 plus detect: drop char, both interrupts
// - auto rts: interrupt at trigger, deassert above
// - auto rts: reassert below lower level
// - rts needs software assert; else plain output
// - auto cts: high halts, low resumes transmit
// - summary: inverted tx flags low, rx high
// - summary driven on bus while select low
// - divisor bytes set at power-up only
// - reset values for control and status registers
// - modem deltas zero, status inverted pins
// - interrupt pin state during reset by select
// - enhanced enable gates protected bit writes
`default_nettype none
package ufc_pkg;
	// =====================================================
	// register offsets (address lines)
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam logic [2:0] ADDR_SPR = 3'h7;
	localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
	localparam int LCR_DIV_BIT = 7;
	// =====================================================
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ISR = 8'h01;
	localparam logic [7:0] RST_ONES = 8'hFF;
	localparam logic [7:0] DIV_HIGH_POWERUP = 8'h00;
	localparam logic [7:0] DIV_LOW_POWERUP = 8'h01;
	// =====================================================
	// field positions
	localparam int EFR_ENH_BIT = 4;
	localparam int EFR_SPEC_BIT = 5;
	localparam int EFR_RTS_BIT = 6;
	localparam int EFR_CTS_BIT = 7;
	localparam int IER_RX_BIT = 0;
	localparam int IER_MODEM_BIT = 3;
	localparam int IER_SPEC_BIT = 5;
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_IRQ_EN_BIT = 3;
	localparam logic [1:0] RXFC_OFF = 2'b00;
	localparam logic [1:0] RXFC_SECOND = 2'b01;
	localparam logic [1:0] RXFC_FIRST = 2'b10;
	localparam logic [1:0] RXFC_BOTH = 2'b11;
	localparam logic [7:0] ISR_NONE = 8'h01;
	localparam logic [7:0] ISR_RXDATA = 8'h04;
	localparam logic [7:0] ISR_SPECIAL = 8'h10;
	localparam logic [7:0] ISR_MODEM = 8'h00;
	// =====================================================
	// receive fifo and trigger levels
	localparam int RX_FIFO_DEPTH = 8;
	localparam logic [3:0] TRIG_L0 = 4'h1;
	localparam logic [3:0] TRIG_L1 = 4'h2;
	localparam logic [3:0] TRIG_L2 = 4'h4;
	localparam logic [3:0] TRIG_L3 = 4'h6;
	localparam logic [3:0] TRIG_HYST = 4'h1;
endpackage : ufc_pkg
`default_nettype wire

// >>> hw/ufc_rx_fifo.sv
// receive fifo: valid/ready on both sides, occupancy count out
// assumes one clock and a synchronous reset
`default_nettype none
module ufc_rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0] count_q, count_d;
	logic push, pop;

	// =====================================================
	// handshake and pointers
	assign inReady = count_q != (AW+1)'(DEPTH);
	assign outValid = count_q != '0;
	assign outData = mem_q[rdPtr_q];
	assign count = count_q;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		mem_d = mem_q;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		count_d = count_q;
		if (push) begin
			mem_d[wrPtr_q] = inData;
			wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
		end
		if (pop) begin
			rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
		end
		count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock) begin
		mem_q <= mem_d;
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end
endmodule : ufc_rx_fifo
`default_nettype wire

// >>> verif/ufc_remote_model.sv
// remote serial party: sends characters, takes transmitted ones, drives cts
// assumes send is called one nanosecond after a rising clock edge
`default_nettype none
module ufc_remote_model (
	input wire logic clock,
	output logic [7:0] rxChar,
	output logic rxValid,
	input wire logic rxReady,
	input wire logic [7:0] txChar,
	input wire logic txValid,
	output logic txReady,
	output logic ctsN
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ctsHold = 1'b0;
	logic slow = 1'b0;
	logic [7:0] lastTx;
	event took;
	initial begin
		rxChar = 8'h00;
		rxValid = 1'b0;
		txReady = 1'b1;
	end
	assign ctsN = ctsHold;
	// =====================================================
	// transmit side: accept, stall when slow
	always @(posedge clock) begin
		if (txValid && txReady) begin
			lastTx = txChar;
			-> took;
		end
	end
	always @(posedge clock) begin
		txReady <= #1 slow ? ~txReady : 1'b1;
	end
	// =====================================================
	// receive side: hold until taken or 40 edges pass, then invert the data line
	task automatic send(input logic [7:0] c, output bit ok);
		// one idle edge between transfers
		@(posedge clock);
		#1;
		rxChar = c;
		rxValid = 1'b1;
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clock);
			ok = rxReady;
			#1;
		end
		rxValid = 1'b0;
		rxChar = ~c;
	endtask : send
endmodule : ufc_remote_model
`default_nettype wire

// >>> verif/ufc_channel_asserts.sv
// checker of one uart channel: bus drive, summary, reset levels
// assumes rst synchronous and active high on clock
`default_nettype none
module ufc_channel_asserts (
	input wire logic clock,
	input wire logic rst,
	input wire logic readN,
	input wire logic [7:0] busDataOut,
	input wire logic busDataOe,
	input wire logic fifoSummarySelectN,
	input wire logic [3:0] allTxSpaceN,
	input wire logic [3:0] allRxAvailN,
	input wire logic irqDriveSelect,
	input wire logic irqOut,
	input wire logic irqOe,
	input wire logic rxValid,
	input wire logic rxReady,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic rtsN,
	input wire logic dtrN,
	input wire logic serialTxOut,
	input wire logic infraredTxOut,
	input wire logic txSpaceFlagN,
	input wire logic rxAvailFlagN
);
	timeunit 1ns;
	timeprecision 100ps;
	// =====================================================
	// bus drive and summary
	a_summary_drive: assert property (@(posedge clock) disable iff (rst)
		!fifoSummarySelectN |-> busDataOe)
		else $error("summary select left bus undriven");
	a_bus_release: assert property (@(posedge clock) disable iff (rst)
		readN && fifoSummarySelectN |-> !busDataOe)
		else $error("bus driven while unselected");
	a_summary_bits: assert property (@(posedge clock) disable iff (rst)
		(!fifoSummarySelectN)[*3] ##0 ($past(allRxAvailN, 2) == allRxAvailN
		&& $past(allTxSpaceN, 2) == allTxSpaceN && $stable({allRxAvailN, allTxSpaceN}))
		|-> busDataOut == {allRxAvailN, ~allTxSpaceN})
		else $error("summary bits wrong");
	// =====================================================
	// reset levels
	a_reset_pins: assert property (@(posedge clock)
		rst |=> rtsN && dtrN && rxAvailFlagN && !txSpaceFlagN)
		else $error("flag pins wrong after reset");
	a_serial_idle: assert property (@(posedge clock) disable iff (rst)
		serialTxOut && !infraredTxOut)
		else $error("serial outputs not idle");
	a_irq_select: assert property (@(posedge clock)
		rst && $past(rst) |-> irqOe == irqDriveSelect)
		else $error("interrupt enable wrong in reset");
	a_irq_quiet: assert property (@(posedge clock)
		rst && $past(rst) |-> !irqOut)
		else $error("interrupt high in reset");
	a_rts_reset: assert property (@(posedge clock)
		$fell(rst) |-> $past(rtsN) && rtsN)
		else $error("rts low across reset");
	c_tx_taken: cover property (@(posedge clock) txValid && txReady);
	c_rx_full: cover property (@(posedge clock) rxValid && !rxReady);
	c_rts_halt: cover property (@(posedge clock) disable iff (rst) $rose(rtsN));
endmodule : ufc_channel_asserts
bind ufc_channel ufc_channel_asserts i_chk (.clock, .rst, .readN, .busDataOut, .busDataOe,
	.fifoSummarySelectN, .allTxSpaceN, .allRxAvailN, .irqDriveSelect, .irqOut, .irqOe,
	.rxValid, .rxReady, .txValid, .txReady, .rtsN, .dtrN, .serialTxOut, .infraredTxOut,
	.txSpaceFlagN, .rxAvailFlagN);
`default_nettype wire

// >>> verif/test_ufc_channel.sv
// self-checking bench: one channel against the remote model
// assumes the register banks and reset values of ufc_pkg
`default_nettype none
module test_ufc_channel;
	timeunit 1ns;
	timeprecision 100ps;
	import ufc_pkg::*;
	logic clock, rst = 1'b1, chipSelN = 1'b1, readN = 1'b1, writeN = 1'b1;
	logic fifoSummarySelectN = 1'b1, irqDriveSelect = 1'b0, dsrN = 1'b1, riN = 1'b1, cdN = 1'b1;
	logic [2:0] addr = 3'h0, txLanes = 3'h0, rxLanes = 3'h0;
	logic [7:0] busDataIn = 8'h00, busDataOut, rxChar, txChar, d[8];
	logic busDataOe, irqOut, irqOe, rxValid, rxReady, txValid, txReady, ctsN, rtsN, dtrN;
	logic serialTxOut, infraredTxOut, txSpaceFlagN, rxAvailFlagN;
	wire logic [3:0] allTxSpaceN = {txLanes, txSpaceFlagN};
	wire logic [3:0] allRxAvailN = {rxLanes, rxAvailFlagN};
	logic [7:0] expQ[$], txQ[$];
	int fail_count = 0, check_count = 0;
	int seed = 32'h57e2_4eec;
	bit ok;
	event take;
	ufc_channel i_dut (
		.clock(clock), .rst(rst), .chipSelN(chipSelN), .readN(readN), .writeN(writeN),
		.addr(addr), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
		.fifoSummarySelectN(fifoSummarySelectN), .allTxSpaceN(allTxSpaceN),
		.allRxAvailN(allRxAvailN), .irqDriveSelect(irqDriveSelect), .irqOut(irqOut),
		.irqOe(irqOe), .rxChar(rxChar), .rxValid(rxValid), .rxReady(rxReady), .txChar(txChar),
		.txValid(txValid), .txReady(txReady), .ctsN(ctsN), .dsrN(dsrN), .riN(riN), .cdN(cdN),
		.rtsN(rtsN), .dtrN(dtrN), .serialTxOut(serialTxOut), .infraredTxOut(infraredTxOut),
		.txSpaceFlagN(txSpaceFlagN), .rxAvailFlagN(rxAvailFlagN)
	);
	ufc_remote_model i_remote (
		.clock(clock), .rxChar(rxChar), .rxValid(rxValid), .rxReady(rxReady),
		.txChar(txChar), .txValid(txValid), .txReady(txReady), .ctsN(ctsN)
	);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// =====================================================
	// tasks
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		addr = a;
		busDataIn = v;
		{chipSelN, writeN} = 2'b00;
		tick(1);
		{chipSelN, writeN} = 2'b11;
		tick(1);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		addr = a;
		{chipSelN, readN} = 2'b00;
		tick(1);
		expQ.push_back(e);
		-> take;
		tick(1);
		{chipSelN, readN} = 2'b11;
		tick(1);
	endtask : rd
	task automatic setEfr(input logic [7:0] v);
		wr(ADDR_LCR, LCR_ENH_KEY);
		wr(ADDR_ISR, v);
		wr(ADDR_LCR, 8'h03);
	endtask : setEfr
	task automatic sendc(input logic [7:0] c);
		i_remote.send(c, ok);
		chk("rx taken", 8'h01, 8'(ok));
	endtask : sendc
	task automatic expectTx(input logic [7:0] e);
		int i;
		txQ.push_back(e);
		for (i = 0; i < 60 && txQ.size() != 0; i++) tick(1);
		chk("tx wait", 8'h00, 8'(txQ.size()));
	endtask : expectTx
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// =====================================================
	// watchers
	initial forever begin
		@take;
		chk("read data", expQ.pop_front(), busDataOut);
	end
	initial forever begin
		@(i_remote.took);
		chk("tx char", txQ.size() != 0 ? txQ.pop_front() : 8'hxx, i_remote.lastTx);
	end
	initial begin
		#200000;
		chk("timeout", 8'h00, 8'h01);
		give_verdict();
	end
	// =====================================================
	// scenarios
	initial begin
		{dsrN, riN, cdN} = 3'($random(seed));
		repeat (3) @(posedge clock);
		#1 rst = 1'b0;
		rd(ADDR_IER, RST_ZERO);
		rd(ADDR_ISR, RST_ISR);
		rd(ADDR_LSR, 8'h60);
		rd(ADDR_MSR, {~{cdN, riN, dsrN, ctsN}, 4'h0});
		rd(ADDR_SPR, RST_ONES);
		wr(ADDR_LCR, LCR_ENH_KEY);
		for (int a = 2; a < 8; a++) rd(3'(a), a == 3 ? LCR_ENH_KEY : RST_ZERO);
		for (int a = 4; a < 8; a++) wr(3'(a), 8'h10 + 8'(a));
		for (int a = 4; a < 8; a++) rd(3'(a), 8'h10 + 8'(a));
		wr(ADDR_LCR, 8'h80);
		rd(ADDR_DATA, DIV_LOW_POWERUP);
		rd(ADDR_IER, DIV_HIGH_POWERUP);
		rd(ADDR_ISR, RST_ZERO);
		wr(ADDR_DATA, 8'h34);
		wr(ADDR_IER, 8'h12);
		wr(ADDR_LCR, 8'h03);
		wr(ADDR_IER, 8'hF1);
		rd(ADDR_IER, 8'h01);
		for (int m = 0; m < 2; m++) begin
			setEfr(m ? 8'h31 : 8'h32);
			wr(ADDR_IER, 8'h20);
			sendc(8'hE8);
			sendc(8'h17);
			rd(ADDR_ISR, ISR_SPECIAL);
			rd(ADDR_ISR, ISR_NONE);
			rd(ADDR_DATA, 8'hE8);
			if (m == 0) begin
				rd(ADDR_DATA, 8'h17);
			end else begin
				wr(ADDR_DATA, 8'hA5);
				tick(6);
				sendc(8'h15);
				expectTx(8'hA5);
			end
			chk("rx empty", 8'h01, 8'(rxAvailFlagN));
		end
		// dual compare mode: flow_off_char_one halts, flow_on_char_one resumes, neither stored
		setEfr(8'h13);
		sendc(8'h16);
		wr(ADDR_DATA, 8'hC3);
		tick(6);
		sendc(8'h14);
		expectTx(8'hC3);
		chk("rx empty", 8'h01, 8'(rxAvailFlagN));
		setEfr(8'h90);
		i_remote.ctsHold = 1'b1;
		i_remote.slow = 1'b1;
		wr(ADDR_DATA, 8'h5A);
		tick(8);
		i_remote.ctsHold = 1'b0;
		expectTx(8'h5A);
		i_remote.slow = 1'b0;
		wr(ADDR_MCR, 8'h02);
		chk("rts plain", 8'h00, 8'(rtsN));
		setEfr(8'h50);
		wr(ADDR_ISR, 8'h01);
		wr(ADDR_IER, 8'h01);
		sendc(8'h41);
		rd(ADDR_ISR, ISR_RXDATA);
		chk("irq level", 8'h01, 8'(irqOut));
		chk("rts", 8'h00, 8'(rtsN));
		sendc(8'h42);
		tick(1);
		chk("rts", 8'h01, 8'(rtsN));
		rd(ADDR_DATA, 8'h41);
		chk("rts", 8'h01, 8'(rtsN));
		rd(ADDR_DATA, 8'h42);
		chk("rts", 8'h00, 8'(rtsN));
		irqDriveSelect = 1'b1;
		rst = 1'b1;
		tick(3);
		chk("irq", 8'h02, 8'({irqOe, irqOut}));
		chk("pins", 8'h3A, 8'({rtsN, dtrN, serialTxOut, infraredTxOut, rxAvailFlagN, txSpaceFlagN}));
		rst = 1'b0;
		rd(ADDR_MCR, RST_ZERO);
		wr(ADDR_LCR, 8'h80);
		rd(ADDR_DATA, 8'h34);
		rd(ADDR_IER, 8'h12);
		wr(ADDR_LCR, 8'h03);
		wr(ADDR_ISR, 8'h01);
		for (int i = 0; i < 8; i++) begin
			d[i] = 8'($random(seed));
			sendc(d[i]);
		end
		i_remote.send(8'h77, ok);
		chk("full refusal", 8'h00, 8'(ok));
		for (int i = 0; i < 8; i++) rd(ADDR_DATA, d[i]);
		for (int k = 0; k < 4; k++) begin
			{txLanes, rxLanes} = 6'($random(seed));
			fifoSummarySelectN = 1'b0;
			tick(3);
			expQ.push_back({allRxAvailN, ~allTxSpaceN});
			-> take;
			chk("summary drive", 8'h01, 8'(busDataOe));
			fifoSummarySelectN = 1'b1;
			tick(1);
		end
		give_verdict();
	end
endmodule : test_ufc_channel
`default_nettype wire
